// ---- src/oag_operand_address_generator.sv ----
// operand effective-address generator, one registered stage
// assumes the decoder gives a mode, immediate and the bank register file
// Notes on behaviour
// - short direct maps the immediate byte into the FE20H..FF1FH window
// - address bit 8 clear for byte 20H..FFH, set for 00H..1FH
// - 16-bit short direct operand uses an even address and the next one
// - sfr mode reaches FF00H..FFCFH and FFE0H..FFFFH by immediate byte; FFD0H..FFDFH is still formed here, flagged out_of_window
// - sfrs at FF00H..FF1FH also reachable through short direct
// - 16-bit sfr operand is even addressed, word spans even and odd
// - register indirect uses second pointer pair or base pair of bank
// - opcode 0BH loads accumulator via second pointer pair
// - based mode adds zero-extended offset to base pair, carry dropped
// - based indexed adds zero-extended b or c to base pair, wraps
// - opcode ABH loads accumulator from base pair plus first index
// - indirect, based and indexed reach the whole 64 KB space
// - stack accesses address through the stack pointer automatically
// - stack accesses target internal high-speed ram only; not confined here, others raise stack_fault
// - window FE20H..FEFFH is ram, FF00H..FF1FH is sfr
`timescale 1ns/1ps
module oag_operand_address_generator #(
    parameter int BANKS = 4
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     bank_select_low,
    input  wire logic                     bank_select_high,
    input       oag_pkg::oag_req_s        req,
    input  wire logic [7:0]               opcode,
    input  wire logic                     opcode_valid,
    input  wire logic [BANKS-1:0][15:0]   bank_second,
    input  wire logic [BANKS-1:0][15:0]   bank_base,
    input  wire logic [BANKS-1:0][15:0]   bank_bc,
    input  wire logic [15:0]              stack_pointer,
    output      oag_pkg::oag_rsp_s        rsp,
    output      logic                     stack_fault
);
    oag_pkg::oag_regs_s  regs;
    oag_pkg::oag_rsp_s   rsp_d;
    oag_pkg::oag_rsp_s   rsp_q;
    oag_pkg::oag_mode_e  mode;
    logic                stack_fault_d;
    logic                stack_fault_q;
    logic [15:0]         ea;
    logic                bit8;

    oag_bank_mux #(
        .BANKS         (BANKS)
    ) oag_bank_mux_i (
        .bank_sel      ({bank_select_high, bank_select_low}),
        .bank_second   (bank_second),
        .bank_base     (bank_base),
        .bank_bc       (bank_bc),
        .stack_pointer (stack_pointer),
        .regs          (regs)
    );

    // fixed opcodes decoded here override the decoder's mode
    always_comb
    begin
        mode = req.mode;
        if (opcode_valid && opcode == oag_pkg::OP_LOAD_SECOND)
        begin
            mode = oag_pkg::OAG_MODE_IND_SECOND;
        end
        else if (opcode_valid && opcode == oag_pkg::OP_LOAD_BASE_IDX)
        begin
            mode = oag_pkg::OAG_MODE_IDX_B;
        end
    end

    assign bit8 = (req.imm < oag_pkg::SADDR_SPLIT);

    always_comb
    begin
        case (mode)
            oag_pkg::OAG_MODE_SHORT:
                ea = {oag_pkg::SADDR_HIGH, bit8, req.imm};
            oag_pkg::OAG_MODE_SFR:
                ea = {oag_pkg::SFR_PAGE, req.imm};
            oag_pkg::OAG_MODE_IND_SECOND:
                ea = regs.second_pointer_pair;
            oag_pkg::OAG_MODE_IND_BASE:
                ea = regs.base_pair;
            oag_pkg::OAG_MODE_BASED:
                ea = 16'(regs.base_pair + {8'h00, req.imm});
            oag_pkg::OAG_MODE_IDX_B:
                ea = 16'(regs.base_pair + {8'h00, regs.idx_b});
            oag_pkg::OAG_MODE_IDX_C:
                ea = 16'(regs.base_pair + {8'h00, regs.idx_c});
            oag_pkg::OAG_MODE_STACK:
                ea = regs.stack_pointer;
            default:
                ea = oag_pkg::ADDR_RESET;
        endcase
    end

    function automatic oag_pkg::oag_region_e region_of(input logic [15:0] a);
        if (a >= oag_pkg::SRAM_LO && a <= oag_pkg::SRAM_HI)
            return oag_pkg::OAG_REGION_SRAM;
        else if ((a >= oag_pkg::SFR_LOW_LO && a <= oag_pkg::SFR_LOW_HI) ||
                 a >= oag_pkg::SFR_HIGH_LO)
            return oag_pkg::OAG_REGION_SFR;
        else
            return oag_pkg::OAG_REGION_OTHER;
    endfunction

    always_comb
    begin
        rsp_d.valid  = req.valid || opcode_valid;
        rsp_d.addr   = ea;
        rsp_d.word   = req.word;
        rsp_d.region = region_of(ea);
        // short direct and sfr word operands must name an even address; flagged, not altered
        rsp_d.misaligned = req.word && ea[0] &&
            (mode == oag_pkg::OAG_MODE_SHORT ||
             mode == oag_pkg::OAG_MODE_SFR);
        rsp_d.out_of_window = (mode == oag_pkg::OAG_MODE_SFR) &&
            (ea > oag_pkg::SFR_LOW_HI && ea < oag_pkg::SFR_HIGH_LO);
        stack_fault_d = (mode == oag_pkg::OAG_MODE_STACK) && rsp_d.valid &&
            (rsp_d.region != oag_pkg::OAG_REGION_SRAM);
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q <= rsp_d;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stack_fault_q <= 1'b0;
        end
        else
        begin
            stack_fault_q <= stack_fault_d;
        end
    end

    assign rsp         = rsp_q;
    assign stack_fault = stack_fault_q;

    sequence short_req_s;
        req.valid && !opcode_valid && req.mode == oag_pkg::OAG_MODE_SHORT;
    endsequence

    short_range_a: assert property (
        @(posedge core_clk) disable iff (rst)
        short_req_s |=> rsp.addr >= oag_pkg::SADDR_BASE &&
            rsp.addr <= oag_pkg::SADDR_TOP)
        else $error("short direct address outside window");

    short_bit8_a: assert property (
        @(posedge core_clk) disable iff (rst)
        short_req_s |=> rsp.addr[oag_pkg::SADDR_BIT8] ==
            ($past(req.imm) < oag_pkg::SADDR_SPLIT))
        else $error("short direct bit 8 wrong");

    short_form_a: assert property (
        @(posedge core_clk) disable iff (rst)
        short_req_s |=> rsp.addr[15:9] == oag_pkg::SADDR_HIGH &&
            rsp.addr[7:0] == $past(req.imm))
        else $error("short direct address form wrong");

    word_even_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (req.valid && !opcode_valid && req.word &&
         (req.mode == oag_pkg::OAG_MODE_SHORT ||
          req.mode == oag_pkg::OAG_MODE_SFR))
        |=> rsp.word && rsp.misaligned == rsp.addr[0])
        else $error("odd word operand not flagged");

    sfr_form_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (req.valid && !opcode_valid && req.mode == oag_pkg::OAG_MODE_SFR)
        |=> rsp.addr == {oag_pkg::SFR_PAGE, $past(req.imm)})
        else $error("sfr address form wrong");

    sfr_window_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (req.valid && !opcode_valid && req.mode == oag_pkg::OAG_MODE_SFR)
        |=> rsp.out_of_window ==
            ($past(req.imm) > oag_pkg::SFR_LOW_HI[7:0] &&
             $past(req.imm) < oag_pkg::SFR_HIGH_LO[7:0]))
        else $error("sfr window flag wrong");

    sequence second_load_s;
        opcode_valid && opcode == oag_pkg::OP_LOAD_SECOND;
    endsequence

    second_load_a: assert property (
        @(posedge core_clk) disable iff (rst)
        second_load_s |=> rsp.valid &&
            rsp.addr == $past(regs.second_pointer_pair))
        else $error("load via second pointer pair wrong");

    base_idx_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (opcode_valid && opcode == oag_pkg::OP_LOAD_BASE_IDX) |=>
        rsp.addr == 16'($past(regs.base_pair) + {8'h00, $past(regs.idx_b)}))
        else $error("base plus index address wrong");

    idx_c_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (req.valid && !opcode_valid && req.mode == oag_pkg::OAG_MODE_IDX_C)
        |=> rsp.addr == 16'($past(regs.base_pair) +
            {8'h00, $past(regs.idx_c)}))
        else $error("base plus second index address wrong");

    based_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (req.valid && !opcode_valid && req.mode == oag_pkg::OAG_MODE_BASED)
        |=> rsp.addr == 16'($past(regs.base_pair) + {8'h00, $past(req.imm)}))
        else $error("based address wrong");

    stack_ptr_a: assert property (
        @(posedge core_clk) disable iff (rst)
        (req.valid && !opcode_valid && req.mode == oag_pkg::OAG_MODE_STACK)
        |=> rsp.addr == $past(stack_pointer) &&
            stack_fault == (rsp.region != oag_pkg::OAG_REGION_SRAM))
        else $error("stack address or fault wrong");

    region_map_a: assert property (
        @(posedge core_clk) disable iff (rst)
        rsp.valid && rsp.addr >= oag_pkg::SRAM_LO &&
        rsp.addr <= oag_pkg::SRAM_HI |-> rsp.region ==
        oag_pkg::OAG_REGION_SRAM)
        else $error("ram region misrouted");

endmodule // oag_operand_address_generator

// ---- pkg/oag_pkg.sv ----
// operand address generator: shared constants, modes and carriers
// assumes a single 50 MHz core clock domain and a 16-bit data space
package oag_pkg;

    localparam logic [15:0] SADDR_BASE   = 16'hFE20;
    localparam logic [15:0] SADDR_TOP    = 16'hFF1F;
    localparam logic [7:0]  SADDR_SPLIT  = 8'h20;
    localparam logic [6:0]  SADDR_HIGH   = 7'h7F;
    localparam int          SADDR_BIT8   = 8;
    localparam logic [15:0] SFR_LOW_LO   = 16'hFF00;
    localparam logic [15:0] SFR_LOW_HI   = 16'hFFCF;
    localparam logic [15:0] SFR_HIGH_LO  = 16'hFFE0;
    localparam logic [7:0]  SFR_PAGE     = 8'hFF;
    localparam logic [15:0] SRAM_LO      = 16'hFE20;
    localparam logic [15:0] SRAM_HI      = 16'hFEFF;
    localparam logic [7:0]  OP_LOAD_SECOND   = 8'h0B;
    localparam logic [7:0]  OP_LOAD_BASE_IDX = 8'hAB;
    localparam logic [15:0] ADDR_RESET   = 16'h0000;
    localparam int          CLK_MHZ      = 50;
    localparam int          CLK_PERIOD_NS = 1000 / CLK_MHZ;

    typedef enum logic [3:0] {
        OAG_MODE_NONE,
        OAG_MODE_SHORT,
        OAG_MODE_SFR,
        OAG_MODE_IND_SECOND,
        OAG_MODE_IND_BASE,
        OAG_MODE_BASED,
        OAG_MODE_IDX_B,
        OAG_MODE_IDX_C,
        OAG_MODE_STACK
    } oag_mode_e;

    typedef enum logic [1:0] {
        OAG_REGION_OTHER,
        OAG_REGION_SRAM,
        OAG_REGION_SFR
    } oag_region_e;

    // decoded request from the instruction decoder
    typedef struct packed {
        logic        valid;
        oag_mode_e   mode;
        logic [7:0]  imm;
        logic        word;
    } oag_req_s;

    // register file view of the selected bank and the stack pointer
    typedef struct packed {
        logic [15:0] second_pointer_pair;
        logic [15:0] base_pair;
        logic [7:0]  idx_b;
        logic [7:0]  idx_c;
        logic [15:0] stack_pointer;
    } oag_regs_s;

    // answer to the memory and register-space bus
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic        word;
        logic        misaligned;
        logic        out_of_window;
        oag_region_e region;
    } oag_rsp_s;

endpackage

// ---- src/oag_bank_mux.sv ----
// register bank view selector
// assumes a flat array of four banks, each holding the pair registers
`timescale 1ns/1ps
module oag_bank_mux #(
    parameter int BANKS = 4
) (
    input  wire logic [1:0]                       bank_sel,
    input  wire logic [BANKS-1:0][15:0]           bank_second,
    input  wire logic [BANKS-1:0][15:0]           bank_base,
    input  wire logic [BANKS-1:0][15:0]           bank_bc,
    input  wire logic [15:0]                      stack_pointer,
    output      oag_pkg::oag_regs_s               regs
);
    always_comb
    begin
        regs.second_pointer_pair = bank_second[bank_sel];
        regs.base_pair           = bank_base[bank_sel];
        regs.idx_b               = bank_bc[bank_sel][15:8];
        regs.idx_c               = bank_bc[bank_sel][7:0];
        regs.stack_pointer       = stack_pointer;
    end
endmodule // oag_bank_mux

// ---- tb/oag_regfile_model.sv ----
// bank register file and stack pointer model beside the address generator
// assumes the bench writes one bank per cycle, taken at core_clk rise
`timescale 1ns/1ps
module oag_regfile_model (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              wr_en,
    input  wire logic [1:0]        wr_bank,
    input  wire logic [47:0]       wr_pairs,
    input  wire logic [15:0]       wr_sp,
    input  wire logic              sp_unchecked,
    output logic      [3:0][15:0]  bank_second,
    output logic      [3:0][15:0]  bank_base,
    output logic      [3:0][15:0]  bank_bc,
    output logic      [15:0]       stack_pointer
);
    always @(posedge core_clk)
    begin
        if (rst)
        begin
            bank_second <= '0;
            bank_base <= '0;
            bank_bc <= '0;
            stack_pointer <= 16'hFE20;
        end
        else if (wr_en)
        begin
            bank_second[wr_bank] <= wr_pairs[47:32];
            bank_base[wr_bank] <= wr_pairs[31:16];
            bank_bc[wr_bank] <= wr_pairs[15:0];
            // software keeps the stack in ram unless told not to
            if (sp_unchecked || wr_sp inside {[16'hFE20:16'hFEFF]})
                stack_pointer <= wr_sp;
            else
                stack_pointer <= {8'hFE, wr_sp[7:0] | 8'h20};
        end
    end
endmodule // oag_regfile_model

// ---- tb/test_operand_address_generator.sv ----
// self-checking bench for the operand address generator
// assumes the register file model drives the bank inputs
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_operand_address_generator;
    logic                 core_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 bank_select_low = 1'b0;
    logic                 bank_select_high = 1'b0;
    oag_pkg::oag_req_s    req = '0;
    logic [7:0]           opcode = 8'h00;
    logic                 opcode_valid = 1'b0;
    logic                 wr_en = 1'b0;
    logic [1:0]           wr_bank = 2'h0;
    logic [47:0]          wr_pairs = 48'h0;
    logic [15:0]          wr_sp = 16'hFE20;
    logic                 sp_unchecked = 1'b0;
    logic [3:0][15:0]     bank_second;
    logic [3:0][15:0]     bank_base;
    logic [3:0][15:0]     bank_bc;
    logic [15:0]          stack_pointer;
    oag_pkg::oag_rsp_s    rsp;
    logic                 stack_fault;
    oag_pkg::oag_rsp_s    note_r[$];
    logic                 note_f[$];
    oag_pkg::oag_rsp_s    ex_r;
    logic                 ex_f;
    int                   mismatches = 0;
    int                   n_checks = 0;
    int                   cycles = 0;
    int                   seed = 32'h0BA7D9DA;
    logic [31:0]          r;
    logic [7:0]           imms[10] = '{8'h00, 8'h1F, 8'h20, 8'hFF, 8'h10,
                                       8'hCF, 8'hD0, 8'hDF, 8'hE0, 8'h21};

    oag_regfile_model oag_regfile_model_i (.core_clk(core_clk), .rst(rst),
        .wr_en(wr_en), .wr_bank(wr_bank), .wr_pairs(wr_pairs), .wr_sp(wr_sp),
        .sp_unchecked(sp_unchecked), .bank_second(bank_second),
        .bank_base(bank_base), .bank_bc(bank_bc),
        .stack_pointer(stack_pointer));
    oag_operand_address_generator oag_operand_address_generator_i (
        .core_clk(core_clk), .rst(rst), .bank_select_low(bank_select_low),
        .bank_select_high(bank_select_high), .req(req), .opcode(opcode),
        .opcode_valid(opcode_valid), .bank_second(bank_second),
        .bank_base(bank_base),
        .bank_bc(bank_bc), .stack_pointer(stack_pointer), .rsp(rsp),
        .stack_fault(stack_fault));

    always #(oag_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

    task automatic conclude();
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // expected answer from the inputs that the next edge takes
    task automatic note();
        oag_pkg::oag_rsp_s e;
        logic [3:0]        m;
        logic [1:0]        b;
        e = '0;
        b = {bank_select_high, bank_select_low};
        m = req.mode;
        if (opcode_valid && opcode == 8'h0B) m = 4'h3;
        if (opcode_valid && opcode == 8'hAB) m = 4'h6;
        e.valid = 1'b1;
        e.word = req.word;
        case (m)
            4'h1: e.addr = {7'h7F, req.imm < 8'h20, req.imm};
            4'h2: e.addr = {8'hFF, req.imm};
            4'h3: e.addr = bank_second[b];
            4'h4: e.addr = bank_base[b];
            4'h5: e.addr = bank_base[b] + {8'h00, req.imm};
            4'h6: e.addr = bank_base[b] + {8'h00, bank_bc[b][15:8]};
            4'h7: e.addr = bank_base[b] + {8'h00, bank_bc[b][7:0]};
            default: e.addr = stack_pointer;
        endcase
        e.misaligned = req.word && req.imm[0] && (m == 4'h1 || m == 4'h2);
        e.out_of_window = m == 4'h2 && req.imm[7:4] == 4'hD;
        if (e.addr inside {[16'hFE20:16'hFEFF]})
            e.region = oag_pkg::OAG_REGION_SRAM;
        else if (e.addr >= 16'hFF00 && !(e.addr inside {[16'hFFD0:16'hFFDF]}))
            e.region = oag_pkg::OAG_REGION_SFR;
        note_f.push_back(m == 4'h8 && e.region != oag_pkg::OAG_REGION_SRAM);
        note_r.push_back(e);
    endtask

    task automatic step(input logic [3:0] m, input logic [7:0] i,
                        input logic w, input logic ov, input logic [7:0] op);
        logic [31:0] x;
        logic [31:0] y;
        x = $random(seed);
        y = $random(seed);
        @(posedge core_clk);
        req <= '{1'b1, oag_pkg::oag_mode_e'(m), i, w};
        opcode_valid <= ov;
        opcode <= op;
        bank_select_low <= x[0];
        bank_select_high <= x[1];
        wr_en <= 1'b1;
        wr_bank <= x[3:2];
        wr_pairs <= {y[31:16], y[15:8] | {8{x[4]}}, y[7:0], x[31:16]};
        wr_sp <= x[23:8];
        sp_unchecked <= x[6:5] == 2'h0;
        #1 note();
    endtask

    task automatic restart();
        @(posedge core_clk);
        rst <= 1'b1;
        req <= '0;
        opcode_valid <= 1'b0;
        repeat (1) @(posedge core_clk);
        rst <= 1'b0;
        #1 `CHK("reset", 1'b1, ({stack_fault, rsp} == '0))
    endtask

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            mismatches++;
            conclude();
        end
    end

    always @(posedge core_clk)
    begin
        if (rsp.valid === 1'b1)
        begin
            if (note_r.size() == 0)
                `CHK("unexpected", 1'b0, 1'b1)
            else
            begin
                ex_r = note_r.pop_front();
                ex_f = note_f.pop_front();
                `CHK("addr", ex_r.addr, rsp.addr)
                `CHK("region", ex_r.region, rsp.region)
                `CHK("misaligned", ex_r.misaligned, rsp.misaligned)
                `CHK("oow", ex_r.out_of_window, rsp.out_of_window)
                `CHK("word", ex_r.word, rsp.word)
                `CHK("fault", ex_f, stack_fault)
            end
        end
    end

    initial
    begin
        restart();
        for (int w = 0; w < 2; w++)
            foreach (imms[k])
            begin
                step(4'h1, imms[k], w[0], 1'b0, 8'h00);
                step(4'h2, imms[k], w[0], 1'b0, 8'h00);
            end
        step(4'h1, 8'h40, 1'b0, 1'b1, 8'h0B);
        step(4'h2, 8'h40, 1'b0, 1'b1, 8'hAB);
        for (int n = 0; n < 1700; n++)
        begin
            r = $random(seed);
            if (n == 1500) restart();
            step(4'h1 + {1'b0, r[2:0]}, r[15:8], r[16], r[20:18] == 3'h0,
                 r[21] ? 8'hAB : 8'h0B);
        end
        @(posedge core_clk);
        req <= '0;
        opcode_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 `CHK("drained", 0, note_r.size())
        conclude();
    end
endmodule // test_operand_address_generator
